/* File: design/lics_charger.v */
// charge state machine with apb control and status
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lics_defs.vh"
module lics_charger #(
    parameter [31:0] TIMEOUT_CYCLES = `LICS_TCHG_S * `LICS_CLK_HZ // overall charge timeout
) (
    // clock, reset, enable
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // measurements, millivolts and milliamps
    input wire [15:0] battery_voltage,
    input wire [15:0] term_voltage,
    input wire [15:0] charger_supply_input,
    input wire [15:0] charge_current,
    input wire [15:0] fast_charge_current_setting,
    // mode inputs
    input wire ac_input_select,
    input wire charge_enable,
    // charger drive
    output reg charger_on,
    output reg cv_mode,
    output reg [15:0] current_command,
    output reg batt_high_z,
    // status pin, open drain
    output reg charge_status_output_n,
    output reg charge_status_oe,
    // interrupt
    output wire irq
);
    // overview of the block:
    // one state register walks the charge cycle
    // precondition, fast charge, top-off, sleep
    // suspend and no-supply states sit outside the cycle
    // timeout fault is sticky until supply or enable drops
    // a single cycle counter times precondition and fast charge
    // precondition limit is a third of the overall limit
    // fast charge keeps the counter running from precondition
    // counter clears on every other state change
    // counter also clears while sleeping or without supply
    // cv flag is latched once the cell reaches termination
    // charger drive outputs except cv_mode follow the state one edge later
    // status pin is open drain, pulled low while charging
    // apb side holds control, irq status, irq mask, timer
    // all state freezes while clk_en is low
    // measurements are plain binary levels, already sampled
    // no synchroniser here: inputs are taken as synchronous
    // hazard: comparisons use raw levels, no glitch filter
    // the far side must hold levels steady for an edge
    // supply checks override every other transition

    // state and timer
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [31:0] timer_r;
    reg supply_ok_r;
    reg [1:0] ctrl_r; // bit0 software enable, bit1 force suspend
    reg [`LICS_IRQ_W-1:0] irq_stat_r;
    reg [`LICS_IRQ_W-1:0] irq_mask_r;
    reg [2:0] state_d_r;
    reg supply_d_r;

    // thresholds below are pure combinational arithmetic
    // the percent products are 24 bits wide so nothing overflows
    // a 16 bit setting times a percent below 100 fits 23 bits
    // the quotient is cut back to 16 bits on purpose
    // the cut is safe: the quotient never exceeds the setting
    // the 10 or 5 percent choice follows the ac select input
    // precondition uses a fixed 12 percent share
    // release points for the supply checks add hysteresis
    // undervoltage release sits 800 mv above the trip point
    // overvoltage release sits 350 mv below the trip point
    // run_en gathers the pin enable and both control bits
    // derived thresholds
    wire [31:0] pre_limit = TIMEOUT_CYCLES / `LICS_PRE_DIV;
    wire [23:0] eoc_prod = fast_charge_current_setting *
                           (ac_input_select ? `LICS_EOC_HI_PCT : `LICS_EOC_LO_PCT);
    wire [23:0] eoc_quo = eoc_prod / `LICS_PCT_FULL; // full-width quotient
    wire [15:0] eoc_ma = eoc_quo[15:0];
    wire [23:0] pre_prod = fast_charge_current_setting * `LICS_PRE_PCT;
    wire [23:0] pre_quo = pre_prod / `LICS_PCT_FULL; // full-width quotient
    wire [15:0] pre_ma = pre_quo[15:0];
    wire [16:0] uvlo_rel = {1'b0, `LICS_UVLO_MV} + {1'b0, `LICS_UVLO_HYST_MV};
    wire [15:0] ovp_rel = `LICS_OVP_MV - `LICS_OVP_HYST_MV;
    wire run_en = charge_enable & ctrl_r[0] & ~ctrl_r[1];
    wire batt_pre_ok = battery_voltage > `LICS_PRECOND_MV;
    wire batt_at_term = battery_voltage >= term_voltage;
    wire eoc_hit = charge_current < eoc_ma;
    wire cv_done = charge_current <= eoc_ma;

    // supply flag: cleared at once when the input leaves the band
    // set again only inside the narrower release band
    // between trip and release points the flag keeps its value
    // this keeps the charger from chattering on a noisy input
    // the flag starts low, so reset always begins without supply
    // a drop of the flag raises the supply-lost event
    // supply valid with hysteresis on both thresholds
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_ok_r <= 1'b0;
        end else if (clk_en) begin
            if (charger_supply_input < `LICS_UVLO_MV || charger_supply_input > `LICS_OVP_MV) begin
                supply_ok_r <= 1'b0;
            end else if ({1'b0, charger_supply_input} >= uvlo_rel && charger_supply_input <= ovp_rel) begin
                supply_ok_r <= 1'b1;
            end
        end
    end

    // transition priority, highest first:
    // no valid supply wins over everything
    // suspend wins over the charge cycle itself
    // inside the cycle each state checks its own exit
    // precondition prefers success over timeout in one cycle
    // fast charge prefers top-off over timeout in one cycle
    // fault only leaves through supply loss or suspend
    // unknown codes fall back to the no-supply state
    // next state
    always @* begin
        state_nxt = state_r;
        if (!supply_ok_r) begin
            state_nxt = `LICS_ST_NOSUPPLY;
        end else if (!run_en) begin
            state_nxt = `LICS_ST_SUSPEND;
        end else begin
            case (state_r)
                `LICS_ST_NOSUPPLY: begin
                    state_nxt = `LICS_ST_PRECOND;
                end
                `LICS_ST_SUSPEND: begin
                    state_nxt = `LICS_ST_PRECOND;
                end
                `LICS_ST_PRECOND: begin
                    if (batt_pre_ok) begin
                        state_nxt = `LICS_ST_FAST;
                    end else if (timer_r >= pre_limit) begin
                        state_nxt = `LICS_ST_FAULT;
                    end
                end
                `LICS_ST_FAST: begin
                    if (cv_mode && cv_done) begin
                        state_nxt = `LICS_ST_TOPOFF;
                    end else if (timer_r >= TIMEOUT_CYCLES) begin
                        state_nxt = `LICS_ST_FAULT;
                    end
                end
                `LICS_ST_TOPOFF: begin
                    if (eoc_hit) begin
                        state_nxt = `LICS_ST_SLEEP;
                    end
                end
                `LICS_ST_SLEEP: begin
                    if (battery_voltage < term_voltage) begin
                        state_nxt = `LICS_ST_FAST;
                    end
                end
                `LICS_ST_FAULT: begin
                    state_nxt = `LICS_ST_FAULT;
                end
                default: begin
                    state_nxt = `LICS_ST_NOSUPPLY;
                end
            endcase
        end
    end

    // state register, cycle counter and cv flag
    // counter saturates instead of wrapping to zero
    // a wrap would silently re-arm the timeouts
    // entering fast charge from precondition keeps the count running
    // so the fast-charge limit covers the whole cycle
    // cv flag only sets while already in fast charge
    // the flag is forced on in top-off and off elsewhere
    // state, timer and cv latch
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `LICS_ST_NOSUPPLY;
            timer_r <= 32'h0;
            cv_mode <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            if (state_nxt != state_r && state_nxt != `LICS_ST_FAST) begin
                timer_r <= 32'h0;
            end else if (state_r == `LICS_ST_SLEEP || state_r == `LICS_ST_NOSUPPLY) begin
                timer_r <= 32'h0; // fresh timer for the new cycle
            end else if (timer_r != 32'hffff_ffff) begin
                timer_r <= timer_r + 32'h1;
            end
            if (state_nxt == `LICS_ST_FAST) begin
                cv_mode <= cv_mode | (state_r == `LICS_ST_FAST && batt_at_term);
            end else begin
                cv_mode <= (state_nxt == `LICS_ST_TOPOFF);
            end
        end
    end

    // drive outputs are registered from the current state
    // one edge of lag against the state is accepted
    // the battery sees high impedance whenever not charging
    // the status pin enable is high only while charging
    // its data bit stays low so the pin only ever sinks
    // charger drive and status pin
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charger_on <= 1'b0;
            current_command <= 16'h0;
            batt_high_z <= 1'b1;
            charge_status_output_n <= 1'b1;
            charge_status_oe <= 1'b0;
        end else if (clk_en) begin
            case (state_r)
                `LICS_ST_PRECOND: begin
                    charger_on <= 1'b1;
                    current_command <= pre_ma;
                    batt_high_z <= 1'b0;
                end
                `LICS_ST_FAST, `LICS_ST_TOPOFF: begin
                    charger_on <= 1'b1;
                    current_command <= fast_charge_current_setting;
                    batt_high_z <= 1'b0;
                end
                default: begin
                    charger_on <= 1'b0;
                    current_command <= 16'h0;
                    batt_high_z <= 1'b1;
                end
            endcase
            // pin pulled low only while charging
            charge_status_oe <= (state_r == `LICS_ST_PRECOND || state_r == `LICS_ST_FAST ||
                                 state_r == `LICS_ST_TOPOFF);
            charge_status_output_n <= 1'b0;
        end
    end

    // bus side: every access completes in its first access cycle
    // no error response, unmapped reads return zero
    // writes and read-clear only act while clk_en is high
    // an access during a frozen cycle is lost, not delayed
    // software must keep clk_en high around register access
    // apb decode, zero wait
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    wire wr = psel & penable & pwrite & clk_en;
    wire rd_stat = psel & penable & ~pwrite & clk_en & (paddr == `LICS_OFF_IRQ_STAT);

    // events are single-cycle pulses built from delayed copies
    // entering fault, entering sleep, losing supply
    // delayed copies reset to the idle values of their sources
    // so no false event follows the release of reset
    // events: fault, done, supply loss
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_d_r <= `LICS_ST_NOSUPPLY;
            supply_d_r <= 1'b0;
        end else if (clk_en) begin
            state_d_r <= state_r;
            supply_d_r <= supply_ok_r;
        end
    end
    wire [`LICS_IRQ_W-1:0] evt;
    assign evt[`LICS_IRQ_FAULT] = (state_r == `LICS_ST_FAULT) && (state_d_r != `LICS_ST_FAULT);
    assign evt[`LICS_IRQ_DONE] = (state_r == `LICS_ST_SLEEP) && (state_d_r != `LICS_ST_SLEEP);
    assign evt[`LICS_IRQ_SUPPLY] = supply_d_r & ~supply_ok_r;

    // control resets with the software enable already set
    // a status read clears the sticky bits it returned
    // an event in the same cycle as the clear survives it
    // irq is a plain level of unmasked sticky bits
    // control, mask, sticky status (set wins over read clear)
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `LICS_CTRL_RST;
            irq_mask_r <= {`LICS_IRQ_W{1'b0}};
            irq_stat_r <= {`LICS_IRQ_W{1'b0}};
        end else if (clk_en) begin
            if (wr && paddr == `LICS_OFF_CTRL) begin
                ctrl_r <= pwdata[1:0];
            end
            if (wr && paddr == `LICS_OFF_IRQ_MASK) begin
                irq_mask_r <= pwdata[`LICS_IRQ_W-1:0];
            end
            irq_stat_r <= (rd_stat ? {`LICS_IRQ_W{1'b0}} : irq_stat_r) | evt;
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // read data is a pure mux of flip-flops, no side effects
    // the read-clear lives in the status process, not here
    // status word: state, charger on, cv flag, supply flag
    // read mux, combinational over registered sources
    always @* begin
        case (paddr)
            `LICS_OFF_CTRL: prdata = {30'h0, ctrl_r};
            `LICS_OFF_STATUS: prdata = {26'h0, supply_ok_r, cv_mode, charger_on, state_r};
            `LICS_OFF_IRQ_STAT: prdata = {29'h0, irq_stat_r};
            `LICS_OFF_IRQ_MASK: prdata = {29'h0, irq_mask_r};
            `LICS_OFF_TIMER: prdata = timer_r;
            default: prdata = 32'h0;
        endcase
    end
endmodule
`default_nettype wire

/* File: design/lics_defs.vh */
// constants for the li-ion charge state machine
// What this block does
// - new cycle starts in precondition
// - leave precondition when battery above 2.85v
// - precondition current is 12% of setting
// - precondition timeout gives timeout fault
// - constant current until termination voltage, then cv
// - cv to top-off at 10% or 5%
// - fast-charge timeout gives timeout fault
// - top-off ends below eoc, enters sleep
// - sleep and eoc: high impedance, keep monitoring
// - sleep restarts fast charge below termination
// - enable low suspends charger only
// - leaving suspend resets timer, enters precondition
// - charger enabled whenever supply valid and charge_enable high; here it also needs ctrl bit0 set and bit1 clear
// - precondition timeout is third of total
// - undervoltage below 3.0v, resume plus 800mv
// - overvoltage above 6.8v, resume minus 350mv
// - status output asserted only while charging
`ifndef LICS_DEFS_VH
`define LICS_DEFS_VH
// state codes
`define LICS_ST_SUSPEND 3'h0
`define LICS_ST_PRECOND 3'h1
`define LICS_ST_FAST 3'h2
`define LICS_ST_TOPOFF 3'h3
`define LICS_ST_SLEEP 3'h4
`define LICS_ST_FAULT 3'h5
`define LICS_ST_NOSUPPLY 3'h6
// voltages in millivolts, 16 bit
`define LICS_PRECOND_MV 16'h0b22
`define LICS_UVLO_MV 16'h0bb8
`define LICS_UVLO_HYST_MV 16'h0320
`define LICS_OVP_MV 16'h1a90
`define LICS_OVP_HYST_MV 16'h015e
// current fractions in percent
`define LICS_PRE_PCT 8'h0c
`define LICS_EOC_HI_PCT 8'h0a
`define LICS_EOC_LO_PCT 8'h05
`define LICS_PCT_FULL 8'h64
// precondition share of the total timeout
`define LICS_PRE_DIV 32'h3
// clock rate in hz, 10 mhz
`define LICS_CLK_HZ 32'h0098_9680
// default overall timeout, seconds; kept so that seconds times clock fits 32 bits
`define LICS_TCHG_S 32'h0000_012c
// interrupt status bits
`define LICS_IRQ_FAULT 0
`define LICS_IRQ_DONE 1
`define LICS_IRQ_SUPPLY 2
`define LICS_IRQ_W 3
// register byte offsets
`define LICS_OFF_CTRL 12'h000
`define LICS_OFF_STATUS 12'h004
`define LICS_OFF_IRQ_STAT 12'h008
`define LICS_OFF_IRQ_MASK 12'h00c
`define LICS_OFF_TIMER 12'h010
// control reset value: charger enable set
`define LICS_CTRL_RST 2'h1
`endif

/* File: testbench/lics_batt_model.sv */
// cell and supply model on the far side of the charger
`timescale 1ns/1ps
`default_nettype none
module lics_batt_model (
    // charger drive
    input wire logic charger_on,
    input wire logic cv_mode,
    input wire logic [15:0] current_command,
    // levels back to the charger
    output logic [15:0] battery_voltage,
    output logic [15:0] charger_supply_input,
    output logic [15:0] charge_current
);
    logic [15:0] vbat = 16'h09c4; // cell voltage, set by bench
    logic [15:0] vin = 16'h0000; // supply, absent at start
    logic [15:0] taper = 16'h00c8; // current once in cv
    assign battery_voltage = vbat;
    assign charger_supply_input = vin;
    // no current while charger off
    assign charge_current = !charger_on ? 16'h0000 : cv_mode ? taper : current_command;
endmodule
`default_nettype wire

/* File: testbench/lics_charger_sva.sv */
// port assertions for the charge state machine
`timescale 1ns/1ps
`default_nettype none
module lics_charger_sva #(
    parameter [31:0] TIMEOUT_CYCLES = 32'h12c
) (
    // inputs
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire charge_enable,
    input wire [15:0] charger_supply_input,
    input wire [15:0] fast_charge_current_setting,
    // outputs
    input wire charger_on,
    input wire cv_mode,
    input wire [15:0] current_command,
    input wire batt_high_z,
    input wire charge_status_oe,
    input wire irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire [31:0] pre_ma = fast_charge_current_setting * 32'hc / 32'h64; // reduced current
    property p_hz; batt_high_z |-> !charger_on; endproperty
    a_hz: assert property (p_hz) else $error("high-z while charging");
    property p_oe; charge_status_oe == charger_on; endproperty
    a_oe: assert property (p_oe) else $error("status pin off charge");
    property p_susp; (!charge_enable && clk_en)[*4] |-> !charger_on; endproperty
    a_susp: assert property (p_susp) else $error("charging in suspend");
    property p_uvlo; (charger_supply_input < 16'h0bb8 && clk_en)[*5] |-> !charger_on; endproperty
    a_uvlo: assert property (p_uvlo) else $error("charging on low supply");
    property p_ovp; (charger_supply_input > 16'h1a90 && clk_en)[*5] |-> !charger_on; endproperty
    a_ovp: assert property (p_ovp) else $error("charging on high supply");
    property p_cur;
        charger_on && !cv_mode |-> current_command == fast_charge_current_setting || current_command == pre_ma[15:0];
    endproperty
    a_cur: assert property (p_cur) else $error("bad current command");
    property p_cv; cv_mode |-> charger_on; endproperty
    a_cv: assert property (p_cv) else $error("cv with charger off");
    property p_start; $rose(charger_on) |-> !cv_mode; endproperty
    a_start: assert property (p_start) else $error("cycle began in cv");
    c_cv: cover property ($rose(cv_mode));
    c_hz: cover property ($rose(batt_high_z));
    c_irq: cover property ($rose(irq));
endmodule
bind lics_charger lics_charger_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (.*);
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the charge state machine
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic ac_input_select = 1'b1, charge_enable = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q;
    wire [31:0] prdata;
    wire pready, pslverr, charger_on, cv_mode, batt_high_z, charge_status_output_n, charge_status_oe, irq;
    wire [15:0] battery_voltage, charger_supply_input, charge_current, current_command;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    // reset read rows: address and value
    logic [11:0] ra [6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h020};
    logic [31:0] rv [6] = '{32'h1, 32'h6, 32'h0, 32'h0, 32'h0, 32'h0};
    lics_charger #(.TIMEOUT_CYCLES(32'h12c)) u_lics_charger (.*, .term_voltage(16'h1068),
        .fast_charge_current_setting(16'h03e8));
    lics_batt_model u_batt (.*);
    initial forever #50 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("mismatches %0d of %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic st(input logic [2:0] s);
        apb(12'h004, 1'b0, 32'h0);
        chk("state", {29'h0, q[2:0]}, {29'h0, s});
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        w(6);
        rst_n <= 1'b1;
        w(1);
        foreach (ra[i]) begin
            apb(ra[i], 1'b0, 32'h0);
            chk("reset read", q, rv[i]);
        end
        apb(12'h00c, 1'b1, 32'h7);
        u_batt.vin <= 16'h1388;
        w(4);
        st(3'h1);
        chk("pre current", {16'h0, current_command}, 32'h78);
        chk("status oe", {31'h0, charge_status_oe}, 32'h1);
        chk("status n", {31'h0, charge_status_output_n}, 32'h0);
        chk("charger on", {31'h0, charger_on}, 32'h1);
        chk("no error", {30'h0, pslverr, pready}, 32'h1);
        u_batt.vbat <= 16'h0bb8;
        w(4);
        st(3'h2);
        chk("cc current", {16'h0, current_command}, 32'h3e8);
        u_batt.vbat <= 16'h1068;
        u_batt.taper <= 16'h005a;
        ac_input_select <= 1'b0;
        w(4);
        chk("cv", {31'h0, cv_mode}, 32'h1);
        st(3'h2);
        ac_input_select <= 1'b1;
        u_batt.taper <= 16'h0064;
        w(4);
        st(3'h3);
        u_batt.taper <= 16'h005a;
        w(4);
        st(3'h4);
        chk("high z", {31'h0, batt_high_z}, 32'h1);
        chk("status off", {31'h0, charge_status_oe}, 32'h0);
        chk("charger off", {31'h0, charger_on}, 32'h0);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(12'h008, 1'b0, 32'h0);
        chk("irq stat", q, 32'h2);
        chk("irq clr", {31'h0, irq}, 32'h0);
        u_batt.vbat <= 16'h1004;
        w(4);
        st(3'h2);
        charge_enable <= 1'b0;
        u_batt.vbat <= 16'h09c4;
        w(4);
        st(3'h0);
        charge_enable <= 1'b1;
        w(4);
        st(3'h1);
        w(80);
        st(3'h1);
        w(30);
        st(3'h5);
        apb(12'h008, 1'b0, 32'h0);
        chk("fault stat", q, 32'h1);
        u_batt.vbat <= 16'h0bb8;
        w(10);
        st(3'h5);
        u_batt.vin <= 16'h0b54;
        w(4);
        st(3'h6);
        u_batt.vin <= 16'h0e74;
        w(4);
        st(3'h6);
        u_batt.vin <= 16'h0ed8;
        w(6);
        st(3'h2);
        u_batt.vin <= 16'h1af4;
        w(4);
        st(3'h6);
        u_batt.vin <= 16'h1932;
        w(6);
        st(3'h2);
        w(320);
        st(3'h5);
        apb(12'h000, 1'b1, 32'h3);
        st(3'h0);
        chk("susp off", {31'h0, charger_on}, 32'h0);
        apb(12'h000, 1'b1, 32'h1);
        st(3'h2);
        print_verdict();
    end
endmodule
`default_nettype wire
